// ===== xbar_port_cfg.svh
`ifndef XBAR_PORT_CFG_SVH
`define XBAR_PORT_CFG_SVH

// ----------------------------------------------------------------
// Register map, byte-wide registers on a 5-bit address
// ----------------------------------------------------------------
`define REG_ADDR_W     5
`define GRP_DATA       3'h0
`define GRP_MODE       3'h1
`define GRP_CFG        3'h2
`define GRP_CTL        3'h3
`define GRP_ALLOC      3'h4
`define IDX_IN_MODE    2'h3
`define IDX_CTL        2'h0

// ----------------------------------------------------------------
// Crossbar configuration fields
// ----------------------------------------------------------------
`define C0_SMB         0
`define C0_SPI         1
`define C0_PRIMARY_UART       2
`define C0_PCA_LO      3
`define C0_PCA_HI      5
`define C0_ECI         6
`define C0_CPA         7
`define C1_CPB         0
`define C1_T0          1
`define C1_IRQA        2
`define C1_T1          3
`define C1_IRQB        4
`define C1_T2          5
`define C1_T2CR        6
`define C1_SYSTEM_CLOCK_OUTPUT      7
`define C2_CNVA        0
`define C2_SECONDARY_UART       1
`define C2_T4          2
`define C2_T4CR        3
`define C2_GLOBAL_EN   4
`define C2_EXTMEM_LOW  5
`define C2_CNVC        6
`define C2_PULLUP_DIS  7
`define CTL_EXTMEM_MUX 0
`define CTL_SPI_3WIRE  1
`define CTL_U0_MODE0   2
`define CTL_U1_MODE0   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LATCH_RST      8'hFF
`define MODE_RST       8'h00
`define IN_MODE_RST    8'hFF
`define CFG_RST        8'h00
`define CTL_RST        4'h0

// ----------------------------------------------------------------
// Signal indices in priority order, pin positions
// ----------------------------------------------------------------
`define N_SIG          30
`define N_PIN          32
`define SEL_W          5
`define N_PCA          6
`define SIG_TX0        0
`define SIG_RX0        1
`define SIG_NSS        5
`define SIG_SDA        6
`define SIG_SCL        7
`define SIG_RX1        9
`define SIG_PCA_COMPARE_OUTPUT_FIRST       10
`define SIG_IN_ONLY    30'h37F90202
`define P1_BASE        8
`define PIN_ALE        5
`define PIN_RD         6
`define PIN_WR         7

`endif

// ===== xbar_port_pkg.sv
package xbar_port_pkg;

  // Register bus request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bit_mode;
    logic [2:0] bit_sel;
    logic       rmw;
  } bus_req_s;

  // Peripheral side: output value and drive request per signal
  typedef struct packed {
    logic [29:0] value;
    logic [29:0] drive;
  } periph_s;

  // Pad side: output level and enable per pin
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pad_s;

endpackage

// ===== xbar_alloc.sv
`timescale 1ns/1ps
`include "xbar_port_cfg.svh"

module xbar_alloc #(
  parameter int N_SIG = `N_SIG,
  parameter int N_PIN = `N_PIN,
  parameter int SEL_W = `SEL_W
) (
  // Enables and pins to skip
  input  wire logic [N_SIG-1:0]            sig_en_i,
  input  wire logic [N_PIN-1:0]            skip_i,
  // Pin map
  output logic      [N_PIN-1:0]            alloc_o,
  output logic      [N_PIN-1:0][SEL_W-1:0] sel_o
);

  // ----------------------------------------------------------------
  // Priority walk
  // ----------------------------------------------------------------
  // priority walk lowest
  // Pure function of enables and skips, so every enable set has one map
  // deterministic pin map
  always_comb begin
    logic [N_PIN-1:0] used;
    logic             found;
    used    = skip_i;
    found   = 1'b0;
    alloc_o = '0;
    sel_o   = '0;
    for (int s = 0; s < N_SIG; s++) begin
      found = 1'b0;
      if (sig_en_i[s]) begin
        for (int p = 0; p < N_PIN; p++) begin
          if (!found && !used[p]) begin
            alloc_o[p] = 1'b1;
            sel_o[p]   = SEL_W'(s);
            used[p]    = 1'b1;
            found      = 1'b1;
          end
        end
      end
    end
  end

endmodule

// ===== priority_crossbar_port_io.sv
`timescale 1ns/1ps
`include "xbar_port_cfg.svh"

module priority_crossbar_port_io #(
  parameter int N_PORT = 4
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  // Register port
  input  wire xbar_port_pkg::bus_req_s bus_i,
  output logic [7:0]                   rdata_o,
  // Peripherals
  input  wire xbar_port_pkg::periph_s  periph_i,
  output logic [`N_SIG-1:0]            periph_in_o,
  // Pads
  input  wire logic [`N_PIN-1:0]       pins_i,
  output xbar_port_pkg::pad_s          pads_o,
  output logic [`N_PIN-1:0]            pullup_en_o
);
  import xbar_port_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input bus_req_s   req);
    logic [7:0] res;
    res = old;
    if (req.bit_mode) begin
      res[req.bit_sel] = req.wdata[0];
    end else begin
      res = req.wdata;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [N_PORT-1:0][7:0] latch_r,    latch_nxt;
  logic [N_PORT-1:0][7:0] mode_r,     mode_nxt;
  logic [2:0][7:0]        cfg_r,      cfg_nxt;
  logic [7:0]             in_mode_r,  in_mode_nxt;
  logic [3:0]             ctl_r,      ctl_nxt;
  logic [7:0]             rdata_r,    rdata_nxt;
  pad_s                   pads_r,     pads_nxt;
  logic [`N_SIG-1:0]      periph_r,   periph_nxt;
  logic [`N_PIN-1:0]      pullup_r,   pullup_nxt;

  logic [`N_PIN-1:0]              alloc;
  logic [`N_PIN-1:0][`SEL_W-1:0]  sel;
  logic [`N_SIG-1:0]              sig_en;
  logic [`N_PIN-1:0]              skip;
  logic [`N_PIN-1:0]              analog;
  logic [`N_PIN-1:0]              pin_lvl;
  logic [`N_SIG-1:0]              in_only;
  logic [`N_SIG-1:0]              od_forced;
  logic [`N_PIN-1:0]              od_high;
  logic [`N_PIN-1:0]              pp_high;
  logic [`N_PIN-1:0]              in_pin;
  logic [`N_PIN-1:0]              sda_pin;
  logic [2:0]                     grp;
  logic [1:0]                     idx;
  logic                           xbar_en;

  assign grp     = bus_i.addr[4:2];
  assign idx     = bus_i.addr[1:0];
  assign xbar_en = cfg_r[2][`C2_GLOBAL_EN];

  // ----------------------------------------------------------------
  // Signal enables and pin skips
  // ----------------------------------------------------------------
  // enables gate signals
  always_comb begin
    sig_en = '0;
    sig_en[`SIG_TX0]      = cfg_r[0][`C0_PRIMARY_UART];
    sig_en[`SIG_RX0]      = cfg_r[0][`C0_PRIMARY_UART];
    sig_en[4:2]           = {3{cfg_r[0][`C0_SPI]}};
    sig_en[`SIG_NSS]      = cfg_r[0][`C0_SPI] & ~ctl_r[`CTL_SPI_3WIRE];
    sig_en[`SIG_SDA]      = cfg_r[0][`C0_SMB];
    sig_en[`SIG_SCL]      = cfg_r[0][`C0_SMB];
    sig_en[`SIG_RX1-1]    = cfg_r[2][`C2_SECONDARY_UART];
    sig_en[`SIG_RX1]      = cfg_r[2][`C2_SECONDARY_UART];
    for (int i = 0; i < `N_PCA; i++) begin
      sig_en[`SIG_PCA_COMPARE_OUTPUT_FIRST+i] = 3'(i) < cfg_r[0][`C0_PCA_HI:`C0_PCA_LO];
    end
    sig_en[16] = cfg_r[0][`C0_ECI];
    sig_en[17] = cfg_r[0][`C0_CPA];
    sig_en[18] = cfg_r[1][`C1_CPB];
    sig_en[19] = cfg_r[1][`C1_T0];
    sig_en[20] = cfg_r[1][`C1_IRQA];
    sig_en[21] = cfg_r[1][`C1_T1];
    sig_en[22] = cfg_r[1][`C1_IRQB];
    sig_en[23] = cfg_r[1][`C1_T2];
    sig_en[24] = cfg_r[1][`C1_T2CR];
    sig_en[25] = cfg_r[2][`C2_T4];
    sig_en[26] = cfg_r[2][`C2_T4CR];
    sig_en[27] = cfg_r[1][`C1_SYSTEM_CLOCK_OUTPUT];
    sig_en[28] = cfg_r[2][`C2_CNVA];
    sig_en[29] = cfg_r[2][`C2_CNVC];
  end

  always_comb begin
    analog = '0;
    analog[`P1_BASE +: 8] = ~in_mode_r;
    skip   = analog;
    if (cfg_r[2][`C2_EXTMEM_LOW]) begin
      skip[`PIN_WR] = 1'b1;
      skip[`PIN_RD] = 1'b1;
      if (ctl_r[`CTL_EXTMEM_MUX]) begin
        skip[`PIN_ALE] = 1'b1;
      end
    end
  end

  xbar_alloc #(
    .N_SIG (`N_SIG),
    .N_PIN (`N_PIN),
    .SEL_W (`SEL_W)
  ) u_alloc (
    .sig_en_i (sig_en),
    .skip_i   (skip),
    .alloc_o  (alloc),
    .sel_o    (sel)
  );

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  // analog reads zero
  assign pin_lvl = pins_i & ~analog;

  always_comb begin
    logic [7:0] rbyte;
    logic [7:0] wbyte;
    wbyte       = 8'h00;
    latch_nxt   = latch_r;
    mode_nxt    = mode_r;
    cfg_nxt     = cfg_r;
    in_mode_nxt = in_mode_r;
    ctl_nxt     = ctl_r;
    rbyte       = 8'h00;
    rdata_nxt   = 8'h00;
    if (bus_i.wr) begin
      case (grp)
        `GRP_DATA: latch_nxt[idx] = merge_byte(latch_r[idx], bus_i);
        `GRP_MODE: mode_nxt[idx]  = merge_byte(mode_r[idx], bus_i);
        `GRP_CFG: begin
          if (idx == `IDX_IN_MODE) begin
            in_mode_nxt = merge_byte(in_mode_r, bus_i);
          end else begin
            cfg_nxt[idx] = merge_byte(cfg_r[idx], bus_i);
          end
        end
        `GRP_CTL: begin
          if (idx == `IDX_CTL) begin
            wbyte   = merge_byte({4'h0, ctl_r}, bus_i);
            ctl_nxt = wbyte[3:0];
          end
        end
        default: ;
      endcase
    end
    if (bus_i.rd) begin
      case (grp)
        `GRP_DATA: rbyte = bus_i.rmw ? latch_r[idx]
                                     : pin_lvl[idx*8 +: 8];
        `GRP_MODE: rbyte = mode_r[idx];
        `GRP_CFG:  rbyte = (idx == `IDX_IN_MODE) ? in_mode_r : cfg_r[idx];
        `GRP_CTL:  rbyte = (idx == `IDX_CTL) ? {4'h0, ctl_r} : 8'h00;
        `GRP_ALLOC: rbyte = alloc[idx*8 +: 8];
        default:   rbyte = 8'h00;
      endcase
      rdata_nxt = bus_i.bit_mode ? {7'h00, rbyte[bus_i.bit_sel]} : rbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_r   <= {N_PORT{`LATCH_RST}};
      mode_r    <= {N_PORT{`MODE_RST}};
      cfg_r     <= {3{`CFG_RST}};
      in_mode_r <= `IN_MODE_RST;
      ctl_r     <= `CTL_RST;
      rdata_r   <= 8'h00;
    end else begin
      latch_r   <= latch_nxt;
      mode_r    <= mode_nxt;
      cfg_r     <= cfg_nxt;
      in_mode_r <= in_mode_nxt;
      ctl_r     <= ctl_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  // inputs never driven
  // forced open-drain
  // Mode 0 receive carries data both ways, so it may drive
  always_comb begin
    in_only   = `SIG_IN_ONLY;
    od_forced = '0;
    od_forced[`SIG_SDA] = 1'b1;
    od_forced[`SIG_SCL] = 1'b1;
    if (ctl_r[`CTL_U0_MODE0]) begin
      in_only[`SIG_RX0]   = 1'b0;
      od_forced[`SIG_RX0] = 1'b1;
    end
    if (ctl_r[`CTL_U1_MODE0]) begin
      in_only[`SIG_RX1]   = 1'b0;
      od_forced[`SIG_RX1] = 1'b1;
    end
  end

  always_comb begin
    logic [`SEL_W-1:0] s;
    logic              v;
    logic              req;
    logic              od;
    s          = '0;
    v          = 1'b0;
    req        = 1'b0;
    od         = 1'b1;
    pads_nxt   = '0;
    // Unrouted inputs idle high so active-low inputs stay quiet
    periph_nxt = '1;
    pullup_nxt = '0;
    od_high    = '0;
    pp_high    = '0;
    in_pin     = '0;
    sda_pin    = '0;
    for (int p = 0; p < `N_PIN; p++) begin
      s = sel[p];
      if (alloc[p]) begin
        v   = periph_i.value[s];
        req = periph_i.drive[s] & ~in_only[s];
        od  = ~mode_r[p/8][p%8] | od_forced[s];
        periph_nxt[s] = pins_i[p];
        in_pin[p]  = in_only[s];
        sda_pin[p] = (s == `SEL_W'(`SIG_SDA)) | (s == `SEL_W'(`SIG_SCL));
      end else begin
        v   = latch_r[p/8][p%8];
        req = 1'b1;
        od  = ~mode_r[p/8][p%8];
      end
      od_high[p] = od & v;
      pp_high[p] = ~od & v & req;
      pads_nxt.oe[p]  = xbar_en & req & (~od | ~v);
      pads_nxt.out[p] = pads_nxt.oe[p] & v;
      pullup_nxt[p] = ~cfg_r[2][`C2_PULLUP_DIS] & ~analog[p]
                      & ~(pads_nxt.oe[p] & ~v);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pads_r   <= '0;
      periph_r <= '1;
      pullup_r <= '0;
    end else begin
      pads_r   <= pads_nxt;
      periph_r <= periph_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  assign rdata_o     = rdata_r;
  assign pads_o      = pads_r;
  assign periph_in_o = periph_r;
  assign pullup_en_o = pullup_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [`N_PIN-1:0] bad_alloc;
  logic              u1_split;
  logic [7:0]        rd_expect;

  always_comb begin
    bad_alloc = '0;
    u1_split  = 1'b0;
    for (int p = 0; p < `N_PIN; p++) begin
      bad_alloc[p] = alloc[p] & ~sig_en[sel[p]];
    end
    // One half placed without the other flips the flag once
    for (int p = 0; p < `N_PIN; p++) begin
      if (alloc[p] && (sel[p] == `SEL_W'(`SIG_RX1 - 1)
                       || sel[p] == `SEL_W'(`SIG_RX1))) begin
        u1_split = ~u1_split;
      end
    end
    rd_expect = bus_i.rmw ? latch_r[idx] : pin_lvl[idx*8 +: 8];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_uart_fixed_pins: assert property (
    cfg_r[0][`C0_PRIMARY_UART] |-> alloc[0] && alloc[1] && sel[0] == 5'h00
      && sel[1] == 5'h01)
    else $error("primary uart not on port 0 bits 0 and 1");

  a_disabled_unrouted: assert property (
    bad_alloc == '0)
    else $error("disabled signal holds a pin");

  a_serial_group: assert property (
    !u1_split)
    else $error("secondary uart pins split");

  a_drivers_off: assert property (
    !xbar_en |=> pads_o.oe == '0)
    else $error("pin driven before global enable");

  a_input_undriven: assert property (
    xbar_en |=> (pads_o.oe & $past(in_pin)) == '0)
    else $error("peripheral input pin driven");

  a_od_float: assert property (
    ##1 (pads_o.oe & $past(od_high)) == '0)
    else $error("open-drain pin driven high");

  a_pp_high: assert property (
    xbar_en ##0 (pp_high != '0) |=> (pads_o.out & $past(pp_high))
      == $past(pp_high))
    else $error("push-pull one not driven high");

  a_bus_od: assert property (
    ##1 (pads_o.out & pads_o.oe & $past(sda_pin)) == '0)
    else $error("bus pin driven high");

  a_read_data: assert property (
    bus_i.rd && !bus_i.bit_mode && grp == `GRP_DATA
      |=> rdata_o == $past(rd_expect))
    else $error("port read returned wrong source");

  a_rmw_latch: assert property (
    bus_i.rd && bus_i.rmw && !bus_i.bit_mode && grp == `GRP_DATA
      |=> rdata_o == $past(latch_r[idx]))
    else $error("rmw read did not return latch");

  c_uart_enabled: cover property (
    cfg_r[0][`C0_PRIMARY_UART] && xbar_en);

  c_all_serial: cover property (
    cfg_r[0][`C0_SMB] && cfg_r[0][`C0_SPI] && cfg_r[2][`C2_SECONDARY_UART]);

  c_rmw_read: cover property (
    bus_i.rd && bus_i.rmw ##1 rdata_o != 8'h00);

endmodule

// ===== board_model.sv
`timescale 1ns/1ps
module board_model (
  // Clock
  input  wire logic                clk_i,
  // Device side
  input  wire xbar_port_pkg::pad_s pads_i,
  input  wire logic [31:0]         pullup_en_i,
  // Board drivers
  input  wire logic [31:0]         ext_en_i,
  input  wire logic [31:0]         ext_val_i,
  output logic      [31:0]         pins_o
);
  import xbar_port_pkg::*;

  // Undriven wire wanders so a stale level never passes for a match
  logic [31:0] float_r = 32'h5555_5555;

  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // floating pin resolution
  // Board drivers are resistive, so the device driver wins
  always_comb begin
    for (int p = 0; p < 32; p++) begin
      if (pads_i.oe[p]) begin
        pins_o[p] = pads_i.out[p];
      end else if (ext_en_i[p]) begin
        pins_o[p] = ext_val_i[p];
      end else if (pullup_en_i[p]) begin
        pins_o[p] = 1'h1;
      end else begin
        pins_o[p] = float_r[p];
      end
    end
  end
endmodule

// ===== tb_priority_crossbar_port_io.sv
`timescale 1ns/1ps
module tb_priority_crossbar_port_io;
  import xbar_port_pkg::*;

  logic        clk_i       = 1'h0;
  logic        reset_n_i   = 1'h0;
  bus_req_s    bus         = '0;
  periph_s     periph      = '0;
  logic [7:0]  rdata_o;
  logic [29:0] periph_in_o;
  logic [31:0] pins_i;
  logic [31:0] pullup_en_o;
  logic [31:0] ext_val;
  pad_s        pads_o;
  logic [7:0]  exp_q[$];
  logic        rd_d        = 1'h0;
  int          bad_count   = 0;
  int          n_compared  = 0;
  int          seed        = 32'h5cac;
  logic [7:0]  lat;
  logic [7:0]  mode;
  logic [7:0]  oe_x;

  priority_crossbar_port_io priority_crossbar_port_io_inst (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .bus_i       (bus),
    .rdata_o     (rdata_o),
    .periph_i    (periph),
    .periph_in_o (periph_in_o),
    .pins_i      (pins_i),
    .pads_o      (pads_o),
    .pullup_en_o (pullup_en_o)
  );

  board_model board_model_inst (
    .clk_i       (clk_i),
    .pads_i      (pads_o),
    .pullup_en_i (pullup_en_o),
    .ext_en_i    (32'hFFFF_FFFF),
    .ext_val_i   (ext_val),
    .pins_o      (pins_i)
  );

  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    rd_d <= bus.rd;
  end

  always @(negedge clk_i) begin
    if (rd_d === 1'h1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 32'h1, 32'h0);
      end else begin
        chk("rdata_o", exp_q.pop_front(), rdata_o);
      end
    end else if (rdata_o !== 8'h00) begin
      chk("rdata_o idle", 32'h0, rdata_o);
    end
  end

  initial begin
    #60000;
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Bus master, called right after a rising edge
  // ----------------------------------------
  task automatic acc(input logic w, r, m, bm, input logic [2:0] bs,
                     input logic [4:0] a, input logic [7:0] d);
    bus <= '{a, d, w, r, bm, bs, m};
    if (r) begin
      exp_q.push_back(d);
    end
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'h1, 1'h0, 1'h0, 1'h0, 3'h0, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    acc(1'h0, 1'h1, 1'h0, 1'h0, 3'h0, a, e);
  endtask

  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic alloc_case(input logic [7:0] c0, c2, ct, im, e0, e1);
    wr(5'h0C, ct);
    wr(5'h0B, im);
    wr(5'h08, c0);
    wr(5'h0A, c2 | 8'h10);
    idle(3);
    rd(5'h10, e0);
    rd(5'h11, e1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    ext_val      <= $random(seed);
    periph.drive <= '1;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    chk("oe after reset", 32'h0, pads_o.oe);
    for (int i = 4; i < 8; i++) begin
      rd(5'(i), 8'h00);
    end
    rd(5'h00, ext_val[7:0]);
    acc(1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 5'h00, 8'hFF);
    rd(5'h1F, 8'h00);
    wr(5'h02, 8'h00);
    wr(5'h06, 8'hFF);
    idle(3);
    chk("oe before enable", 32'h0, pads_o.oe);
    wr(5'h0A, 8'h10);
    lat = $random(seed);
    mode = $random(seed);
    wr(5'h02, lat);
    wr(5'h06, mode);
    idle(3);
    oe_x = mode | ~lat;
    chk("port2 oe", oe_x, pads_o.oe[23:16]);
    chk("port2 out", lat & mode, pads_o.out[23:16]);
    rd(5'h02, (oe_x & lat) | (~oe_x & ext_val[23:16]));
    acc(1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 5'h02, lat);
    acc(1'h1, 1'h0, 1'h0, 1'h1, 3'h0, 5'h02, 8'h01);
    acc(1'h0, 1'h1, 1'h1, 1'h1, 3'h0, 5'h02, 8'h01);
    acc(1'h0, 1'h1, 1'h0, 1'h1, 3'h7, 5'h02,
        {7'h0, oe_x[7] ? lat[7] : ext_val[23]});
    rd(5'h03, ext_val[31:24]);
    for (int n = 0; n < 7; n++) begin
      alloc_case(8'(n << 3), 8'h00, 8'h00, 8'hFF,
                 8'((1 << n) - 1), 8'h00);
    end
    alloc_case(8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00);
    alloc_case(8'h04, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h00);
    alloc_case(8'h07, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00);
    alloc_case(8'h07, 8'h00, 8'h02, 8'hFF, 8'h7F, 8'h00);
    alloc_case(8'h04, 8'h02, 8'h00, 8'hFF, 8'h0F, 8'h00);
    alloc_case(8'h34, 8'h20, 8'h01, 8'hFF, 8'h1F, 8'h07);
    alloc_case(8'h34, 8'h20, 8'h00, 8'hFF, 8'h3F, 8'h03);
    alloc_case(8'h34, 8'h20, 8'h01, 8'hFE, 8'h1F, 8'h0E);
    acc(1'h0, 1'h1, 1'h0, 1'h1, 3'h0, 5'h01, 8'h00);
    idle(2);
    chk("analog pullup", 32'h0, pullup_en_o[8]);
    wr(5'h09, 8'hFF);
    alloc_case(8'hC0, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h03);
    wr(5'h09, 8'h00);
    alloc_case(8'h05, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'h00);
    periph.value <= 30'h41;
    wr(5'h04, 8'hFF);
    wr(5'h00, 8'h00);
    idle(3);
    chk("port0 oe", 8'hF9, pads_o.oe[7:0]);
    chk("port0 out", 8'h01, pads_o.out[7:0]);
    chk("receive in", ext_val[1], periph_in_o[1]);
    periph.value <= 30'h0;
    wr(5'h00, 8'hFF);
    idle(3);
    chk("port0 oe2", 8'hFD, pads_o.oe[7:0]);
    chk("port0 out2", 8'hF0, pads_o.out[7:0]);
    periph.value <= 30'h2;
    wr(5'h0C, 8'h04);
    idle(3);
    chk("mode0 rx high", 32'h0, pads_o.oe[1]);
    periph.value <= 30'h0;
    idle(3);
    chk("mode0 rx low", 32'h1, pads_o.oe[1]);
    chk("mode0 rx out", 32'h0, pads_o.out[1]);
    print_verdict();
  end
endmodule
